// >>> design/csc_regs_top.sv
// csc_regs_top: SMBus target, four setpoint/control registers and a read-only status word, decode and power sequencing
// assumes filtered pins from csc_sync and a host using word transfers only
`timescale 1ns/1ns
module csc_regs_top
    import csc_pkg::*;
#(
    parameter int unsigned ADP_DELAY_CYC = ADP_CYC,
    parameter int unsigned REF_DELAY_CYC = REF_CYC
)(
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe_n_o,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_n_o,
    output logic             alert_o,
    output logic             alert_oe_n_o,
    input  wire logic        adapter_detect_i,
    input  wire logic        gate_drive_full_i,
    input  wire logic        charge_enable_n_i,
    output logic             adapter_path_switch_o,
    output logic             battery_path_switch_o,
    output logic             ref_5v_regulator_en_o,
    output logic             ref_5v_pulldown_o,
    output logic             charge_en_o,
    output logic [6:0]       volt_dac_o,
    output logic             volt_cell4_o,
    output logic             volt_precharge_o,
    output logic [7:0]       current_setpoint_dac_o,
    output logic [7:0]       input_limit_dac_o,
    output logic [15:0]      operating_mode_o
);
    typedef struct packed {
        csc_state_e        st;
        logic [3:0]        bitcnt;
        logic              ackph;
        logic              mack;
        logic              hib;
        logic              drv;
        logic              scl_q;
        logic              sda_q;
        logic [7:0]        sh;
        logic [7:0]        tx;
        logic [7:0]        cmd;
        logic [7:0]        lo;
        logic [15:0]       mode;
        logic [15:0]       vset;
        logic [15:0]       iset;
        logic [15:0]       ilim;
        logic [15:0]       stat;
        logic              alert;
        logic [6:0]        vcode;
        logic              vok;
        logic              cell4;
        logic              pre;
        logic              chg;
        logic              acsw;
        logic [TMR_W-1:0]  adp_cnt;
        logic              adp_rdy;
        logic [REF_W-1:0]  ref_cnt;
        logic              ref_en;
    } csc_regs_s;

    csc_regs_s   q_reg;
    csc_regs_s   q_next;
    logic [4:0]  pin_f;
    logic        scl_f;
    logic        sda_f;
    logic        adp_f;
    logic        gd_f;
    logic        charge_enable_n_n_f;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_c;
    logic        stop_c;
    logic        is_tx;
    logic        accept;
    logic        commit;
    logic        rd_stat;
    logic        ready;
    logic [15:0] wr_word;
    logic [15:0] rd_word;
    logic [15:0] stat_new;

    csc_sync #(
        .W (5)
    ) u_sync (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .d_i    ({scl_i, sda_i, adapter_detect_i, gate_drive_full_i, charge_enable_n_i}),
        .q_o    (pin_f)
    );

    // filtered pins and bus events
    assign scl_f     = pin_f[4];
    assign sda_f     = pin_f[3];
    assign adp_f     = pin_f[2];
    assign gd_f      = pin_f[1];
    assign charge_enable_n_n_f = pin_f[0];
    assign scl_rise  = scl_f & ~q_reg.scl_q;
    assign scl_fall  = ~scl_f & q_reg.scl_q;
    assign start_c   = scl_f & q_reg.scl_q & q_reg.sda_q & ~sda_f;
    assign stop_c    = scl_f & q_reg.scl_q & ~q_reg.sda_q & sda_f;
    assign is_tx     = (q_reg.st == ST_RD);
    assign wr_word   = {q_reg.sh, q_reg.lo};

    // byte acknowledge decision; unknown commands are refused
    always_comb
    begin
        accept = 1'b1;
        if (q_reg.st == ST_ADDR)
        begin
            accept = (q_reg.sh[7:1] == SMB_ADDR[7:1]);
        end
        else if (q_reg.st == ST_CMD)
        begin
            accept = (q_reg.sh == CMD_MODE) || (q_reg.sh == CMD_STAT) ||
                     (q_reg.sh == CMD_ISET) || (q_reg.sh == CMD_VSET) ||
                     (q_reg.sh == CMD_ILIM);
        end
    end

    // read selection; status is read-only
    always_comb
    begin
        rd_word = 16'h0000;
        if (q_reg.cmd == CMD_MODE)
        begin
            rd_word = q_reg.mode;
        end
        else if (q_reg.cmd == CMD_STAT)
        begin
            rd_word = q_reg.stat;
        end
        else if (q_reg.cmd == CMD_ISET)
        begin
            rd_word = q_reg.iset;
        end
        else if (q_reg.cmd == CMD_VSET)
        begin
            rd_word = q_reg.vset;
        end
        else if (q_reg.cmd == CMD_ILIM)
        begin
            rd_word = q_reg.ilim;
        end
    end

    // readiness and the status word seen by the host
    assign ready = adp_f & q_reg.adp_rdy & gd_f & q_reg.ref_en;
    always_comb
    begin
        stat_new               = q_reg.stat;
        stat_new[ST_NOT_READY] = ~ready;
        stat_new[ST_VOR]       = ~q_reg.vok;
        stat_new[ST_BAT_CONN]  = ~q_reg.acsw;
        stat_new[ST_ADP_CONN]  = q_reg.acsw;
    end

    // next state: SMBus engine, registers, decode, sequencing
    always_comb
    begin
        int v;
        int c;
        v             = int'(q_reg.vset & VSET_MASK);
        c             = 0;
        q_next        = q_reg;
        commit        = 1'b0;
        rd_stat       = 1'b0;
        q_next.scl_q  = scl_f;
        q_next.sda_q  = sda_f;
        if (start_c)
        begin
            q_next.st     = ST_ADDR;
            q_next.bitcnt = 4'h0;
            q_next.ackph  = 1'b0;
            q_next.drv    = 1'b0;
        end
        else if (stop_c)
        begin
            q_next.st     = ST_IDLE;
            q_next.bitcnt = 4'h0;
            q_next.ackph  = 1'b0;
            q_next.drv    = 1'b0;
        end
        else if (q_reg.st != ST_IDLE && scl_rise)
        begin
            if (q_reg.bitcnt < 4'h8)
            begin
                q_next.bitcnt = q_reg.bitcnt + 4'h1;
                if (!is_tx)
                begin
                    q_next.sh = {q_reg.sh[6:0], sda_f};
                end
            end
            else if (q_reg.ackph && is_tx)
            begin
                q_next.mack = ~sda_f;
            end
        end
        else if (q_reg.st != ST_IDLE && scl_fall)
        begin
            if (q_reg.bitcnt == 4'h8 && !q_reg.ackph)
            begin
                q_next.ackph = 1'b1;
                q_next.drv   = is_tx ? 1'b0 : accept;
            end
            else if (q_reg.ackph)
            begin
                q_next.ackph  = 1'b0;
                q_next.bitcnt = 4'h0;
                q_next.drv    = 1'b0;
                if (is_tx)
                begin
                    // after the high byte the host should refuse; more reads get fill
                    if (q_reg.mack)
                    begin
                        q_next.tx  = q_reg.hib ? RD_FILL : rd_word[15:8];
                        q_next.hib = 1'b1;
                        q_next.drv = q_reg.hib ? 1'b0 : ~rd_word[15];
                    end
                    else
                    begin
                        q_next.st = ST_IDLE;
                    end
                end
                else if (!accept)
                begin
                    q_next.st = ST_IDLE;
                end
                else if (q_reg.st == ST_ADDR)
                begin
                    if (q_reg.sh[0])
                    begin
                        q_next.st  = ST_RD;
                        q_next.tx  = rd_word[7:0];
                        q_next.hib = 1'b0;
                        q_next.drv = ~rd_word[7];
                        rd_stat    = (q_reg.cmd == CMD_STAT);
                    end
                    else
                    begin
                        q_next.st = ST_CMD;
                    end
                end
                else if (q_reg.st == ST_CMD)
                begin
                    q_next.cmd = q_reg.sh;
                    q_next.st  = ST_WLO;
                end
                else if (q_reg.st == ST_WLO)
                begin
                    q_next.lo = q_reg.sh;
                    q_next.st = ST_WHI;
                end
                else
                begin
                    // a trailing check byte finds the engine idle and is not acked
                    commit    = 1'b1;
                    q_next.st = ST_IDLE;
                end
            end
            else if (is_tx && q_reg.bitcnt != 4'h0)
            begin
                q_next.tx  = {q_reg.tx[6:0], 1'b0};
                q_next.drv = ~q_reg.tx[6];
            end
        end

        // register writes; writes to the status word are dropped
        if (commit)
        begin
            if (q_reg.cmd == CMD_MODE)
            begin
                q_next.mode = wr_word;
            end
            else if (q_reg.cmd == CMD_VSET)
            begin
                q_next.vset = wr_word;
            end
            else if (q_reg.cmd == CMD_ISET)
            begin
                q_next.iset = wr_word;
            end
            else if (q_reg.cmd == CMD_ILIM)
            begin
                q_next.ilim = wr_word;
            end
        end

        // voltage decode; 14.4 V and the 4-cell top saturate at the last code
        q_next.pre   = (v == V_PRE_MV);
        q_next.cell4 = (v >= V4_LO_MV);
        q_next.vok   = q_next.pre || q_next.cell4 ||
                       (v >= V3_LO_MV && v <= V3_HI_MV);
        if (q_next.cell4)
        begin
            c = ((v - V4_LO_MV) * 1000) / V4_STEP_UV;
        end
        else if (v >= V3_LO_MV && v <= V3_HI_MV)
        begin
            c = ((v - V3_LO_MV) * 1000) / V3_STEP_UV;
        end
        q_next.vcode = (c > int'(VCODE_MAX)) ? VCODE_MAX : 7'(c);

        // adapter qualification delay; battery path held meanwhile
        if (!adp_f)
        begin
            q_next.adp_cnt = '0;
            q_next.adp_rdy = 1'b0;
        end
        else if (!q_reg.adp_rdy)
        begin
            if (q_reg.adp_cnt == TMR_W'(ADP_DELAY_CYC - 1))
            begin
                q_next.adp_rdy = 1'b1;
            end
            else
            begin
                q_next.adp_cnt = q_reg.adp_cnt + 1'b1;
            end
        end

        // reference regulator waits for full gate drive with adapter present
        if (!(adp_f && gd_f))
        begin
            q_next.ref_cnt = '0;
            q_next.ref_en  = 1'b0;
        end
        else if (!q_reg.ref_en)
        begin
            if (q_reg.ref_cnt == REF_W'(REF_DELAY_CYC - 1))
            begin
                q_next.ref_en = 1'b1;
            end
            else
            begin
                q_next.ref_cnt = q_reg.ref_cnt + 1'b1;
            end
        end

        // power selector and charge gate; the selector needs no host traffic, charging needs host writes to mode, vset, iset and ilim
        q_next.acsw = adp_f & q_reg.adp_rdy & ~q_reg.mode[MODE_LEARN];
        q_next.chg  = ready & ~charge_enable_n_n_f & ~q_reg.mode[MODE_END_CHG] &
                      q_reg.vok & ~q_reg.mode[MODE_LEARN] &
                      (q_reg.iset[I_HI_BIT:I_LO_BIT] != 8'h00) &
                      (q_reg.ilim[I_HI_BIT:I_LO_BIT] != 8'h00);

        // status and alert: a change in the read cycle keeps the alert set
        q_next.stat  = stat_new;
        q_next.alert = (stat_new != q_reg.stat) ? 1'b1 :
                       (rd_stat ? 1'b0 : q_reg.alert);
    end

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            q_reg      <= '0;
            q_reg.mode <= MODE_RST;
            q_reg.vset <= SETP_RST;
            q_reg.iset <= SETP_RST;
            q_reg.ilim <= SETP_RST;
            q_reg.stat <= STAT_RST;
        end
        else
        begin
            q_reg <= q_next;
        end
    end

    // pins; scl is never stretched
    assign scl_o                  = 1'b0;
    assign scl_oe_n_o             = 1'b1;
    assign sda_o                  = 1'b0;
    assign sda_oe_n_o             = ~q_reg.drv;
    assign alert_o                = 1'b0;
    assign alert_oe_n_o           = ~q_reg.alert;
    assign adapter_path_switch_o  = q_reg.acsw;
    assign battery_path_switch_o  = ~q_reg.acsw;
    assign ref_5v_regulator_en_o  = q_reg.ref_en;
    assign ref_5v_pulldown_o      = ~adp_f;
    assign charge_en_o            = q_reg.chg;
    assign volt_dac_o             = q_reg.vcode;
    assign volt_cell4_o           = q_reg.cell4;
    assign volt_precharge_o       = q_reg.pre;
    assign current_setpoint_dac_o = q_reg.iset[I_HI_BIT:I_LO_BIT];
    assign input_limit_dac_o      = q_reg.ilim[I_HI_BIT:I_LO_BIT];
    assign operating_mode_o       = q_reg.mode;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    property p_addr_ack;
        (scl_fall && q_reg.st == ST_ADDR && q_reg.bitcnt == 4'h8 && !q_reg.ackph)
        |=> (sda_oe_n_o == (q_reg.sh[7:1] != SMB_ADDR[7:1]));
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("address ack wrong");

    property p_no_pec;
        commit |=> q_reg.st == ST_IDLE ##1 !(q_reg.st == ST_WHI);
    endproperty
    a_no_pec: assert property (p_no_pec)
        else $error("engine not idle after word");

    property p_vset_wr;
        (commit && q_reg.cmd == CMD_VSET) |=> q_reg.vset == $past(wr_word);
    endproperty
    a_vset_wr: assert property (p_vset_wr)
        else $error("voltage write lost");

    property p_alert_set;
        $changed(q_reg.stat) |-> q_reg.alert && !alert_oe_n_o;
    endproperty
    a_alert_set: assert property (p_alert_set)
        else $error("status change without alert");

    property p_alert_hold;
        (q_reg.alert && !rd_stat) |=> q_reg.alert;
    endproperty
    a_alert_hold: assert property (p_alert_hold)
        else $error("alert dropped without read");

    property p_trunc;
        (q_reg.vok && !q_reg.pre && $stable(q_reg.vset))
        |-> csc_mv_of(q_reg.vcode, q_reg.cell4) <= int'(q_reg.vset & VSET_MASK);
    endproperty
    a_trunc: assert property (p_trunc)
        else $error("decoded voltage above request");

    property p_clamp;
        ($stable(q_reg.vset) && int'(q_reg.vset & VSET_MASK) > V4_HI_MV)
        |-> q_reg.vcode == VCODE_MAX && q_reg.cell4;
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("voltage not clamped");

    property p_vor;
        !q_reg.vok |=> !charge_en_o && q_reg.stat[ST_VOR];
    endproperty
    a_vor: assert property (p_vor)
        else $error("bad voltage not flagged");

    property p_izero;
        (q_reg.iset[I_HI_BIT:I_LO_BIT] == 8'h00 || q_reg.ilim[I_HI_BIT:I_LO_BIT] == 8'h00)
        |=> !charge_en_o;
    endproperty
    a_izero: assert property (p_izero)
        else $error("charging with zero current");

    property p_adp_delay;
        $rose(q_reg.adp_rdy) |-> $past(q_reg.adp_cnt) == TMR_W'(ADP_DELAY_CYC - 1);
    endproperty
    a_adp_delay: assert property (p_adp_delay)
        else $error("adapter delay wrong");

    property p_ref_delay;
        $rose(q_reg.ref_en)
        |-> $past(q_reg.ref_cnt) == REF_W'(REF_DELAY_CYC - 1) && $past(gd_f);
    endproperty
    a_ref_delay: assert property (p_ref_delay)
        else $error("reference delay wrong");

    property p_learn;
        (!adp_f || q_reg.mode[MODE_LEARN]) |=> battery_path_switch_o && !adapter_path_switch_o;
    endproperty
    a_learn: assert property (p_learn)
        else $error("battery not selected");

    property p_gate;
        (q_reg.mode[MODE_END_CHG] || charge_enable_n_n_f) |=> !charge_en_o;
    endproperty
    a_gate: assert property (p_gate)
        else $error("charging while disabled");

    property p_path_stat;
        $changed(q_reg.acsw) |=> q_reg.alert && q_reg.stat[ST_ADP_CONN] == $past(q_reg.acsw);
    endproperty
    a_path_stat: assert property (p_path_stat)
        else $error("path change not reported");

    c_word_write: cover property (commit && q_reg.cmd == CMD_VSET);
    c_stat_read: cover property (rd_stat && q_reg.alert);
    c_charge: cover property ($rose(q_reg.chg));
    c_learn: cover property (q_reg.adp_rdy && q_reg.mode[MODE_LEARN]);
endmodule : csc_regs_top

// >>> pkg/csc_pkg.sv
// csc_pkg: constants, encodings and helpers of the charger SMBus control registers
// assumes a 10 MHz mclk_i and an SMBus host on open-drain SCL/SDA pins
package csc_pkg;
    localparam logic [7:0]  SMB_ADDR     = 8'h12;
    localparam logic [7:0]  CMD_MODE     = 8'h12;
    localparam logic [7:0]  CMD_STAT     = 8'h13;
    localparam logic [7:0]  CMD_ISET     = 8'h14;
    localparam logic [7:0]  CMD_VSET     = 8'h15;
    localparam logic [7:0]  CMD_ILIM     = 8'h3F;
    localparam logic [7:0]  RD_FILL      = 8'hFF;
    localparam logic [15:0] MODE_RST     = 16'h0001;
    localparam logic [15:0] SETP_RST     = 16'h0000;
    localparam logic [15:0] STAT_RST     = 16'h0061;
    localparam logic [15:0] VSET_MASK    = 16'h7FFE;
    localparam int          MODE_END_CHG = 0;
    localparam int          MODE_LEARN   = 1;
    localparam int          ST_NOT_READY = 0;
    localparam int          ST_VOR       = 5;
    localparam int          ST_BAT_CONN  = 6;
    localparam int          ST_ADP_CONN  = 7;
    localparam int          I_LO_BIT     = 7;
    localparam int          I_HI_BIT     = 14;
    localparam int          V_PRE_MV     = 9000;
    localparam int          V3_LO_MV     = 12000;
    localparam int          V3_HI_MV     = 14400;
    localparam int          V4_LO_MV     = 16000;
    localparam int          V4_HI_MV     = 19200;
    localparam int          V3_STEP_UV   = 18750;
    localparam int          V4_STEP_UV   = 25000;
    localparam logic [6:0]  VCODE_MAX    = 7'h7F;
    localparam int          CLK_HZ       = 10_000_000;
    localparam int          T_ADP_MS     = 500;
    localparam int          T_REF_MS     = 5;
    localparam int          ADP_CYC      = T_ADP_MS * (CLK_HZ / 1000);
    localparam int          REF_CYC      = T_REF_MS * (CLK_HZ / 1000);
    localparam int          TMR_W        = 23;
    localparam int          REF_W        = 16;

    // gray along idle, address, command, low byte, high byte, read
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_CMD  = 3'h3,
        ST_WLO  = 3'h2,
        ST_WHI  = 3'h6,
        ST_RD   = 3'h7
    } csc_state_e;

    // decoded voltage in mV of a DAC code, used only by the decode checks
    function automatic int csc_mv_of(input logic [6:0] code, input logic cell4);
        int c;
        c = int'(code);
        return cell4 ? V4_LO_MV + (c * V4_STEP_UV) / 1000
                     : V3_LO_MV + (c * V3_STEP_UV) / 1000;
    endfunction : csc_mv_of
endpackage : csc_pkg

// >>> design/csc_sync.sv
// csc_sync: three-stage synchroniser with agreement filter for pin inputs
// assumes inputs asynchronous to mclk_i; output moves when stages two and three agree
`timescale 1ns/1ns
module csc_sync
#(
    parameter int W = 1
)(
    input  wire logic         mclk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } csc_sync_s;

    csc_sync_s q_reg;
    csc_sync_s q_next;

    // s1 feeds only s2; a single glitch between s2 and s3 is ignored
    always_comb
    begin
        q_next    = q_reg;
        q_next.s1 = d_i;
        q_next.s2 = q_reg.s1;
        q_next.s3 = q_reg.s2;
        for (int i = 0; i < W; i++)
        begin
            if (q_reg.s2[i] == q_reg.s3[i])
            begin
                q_next.q[i] = q_reg.s2[i];
            end
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            q_reg <= '0;
        end
        else
        begin
            q_reg <= q_next;
        end
    end

    assign q_o = q_reg.q;
endmodule : csc_sync

// >>> tb/csc_host.sv
// csc_host: behavioural smbus host issuing word writes and word reads
// assumes the bench resolves the open-drain wires; 1 on an output means released
`timescale 1ns/1ns
module csc_host
    import csc_pkg::*;
(
    input  wire logic mclk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_o
);
    // both lines released while idle
    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // drive both lines, then hold them for n cycles
    task automatic ph(input logic c, input logic d, input int n);
        scl_o <= c;
        sda_o <= d;
        repeat (n) @(posedge mclk_i);
    endtask : ph
    // sda moves only mid-low, so no false start or stop appears
    task automatic xb(input logic [7:0] d, input logic m, output logic [7:0] q,
                      output logic a);
        logic b;
        for (int i = 7; i >= -1; i--)
        begin
            b = (i < 0) ? m : d[i & 7];
            ph(1'b0, sda_o, 5);
            ph(1'b0, b, 5);
            ph(1'b1, b, 10);
            if (i >= 0)
                q[i & 7] = sda_i;
            else
                a = sda_i;
        end
    endtask : xb
    // p low gives a start or repeated start, p high a stop
    task automatic st(input logic p);
        ph(1'b0, sda_o, 5);
        ph(1'b0, !p, 5);
        ph(1'b1, !p, 10);
        ph(1'b1, p, 10);
    endtask : st
    // word write, low byte first, no check byte appended
    task automatic wr(input logic [7:0] ad, input logic [7:0] c, input logic [15:0] v,
                      output logic ok);
        logic [7:0] q;
        logic       a0, a1, a2, a3;
        st(1'b0);
        xb(ad, 1'b1, q, a0);
        xb(c, 1'b1, q, a1);
        xb(v[7:0], 1'b1, q, a2);
        xb(v[15:8], 1'b1, q, a3);
        st(1'b1);
        ok = !(a0 | a1 | a2 | a3);
    endtask : wr
    // word read through a repeated start; nack after the high byte ends it
    task automatic rd(input logic [7:0] c, output logic [15:0] v, output logic ok);
        logic a0, a1, a2, x;
        st(1'b0);
        xb(SMB_ADDR, 1'b1, v[7:0], a0);
        xb(c, 1'b1, v[7:0], a1);
        st(1'b0);
        xb(SMB_ADDR | 8'h01, 1'b1, v[7:0], a2);
        xb(RD_FILL, 1'b0, v[7:0], x);
        xb(RD_FILL, 1'b1, v[15:8], x);
        st(1'b1);
        ok = !(a0 | a1 | a2);
    endtask : rd
endmodule : csc_host

// >>> tb/tb_top.sv
// tb_top: self-checking bench of csc_regs_top driven by csc_host
// assumes shortened sequencing delays handed in as parameters
`timescale 1ns/1ns
module tb_top
    import csc_pkg::*;
;
    logic mclk_i = 1'b0, rst_i = 1'b1, adapter_detect_i = 1'b0;
    logic gate_drive_full_i = 1'b0, charge_enable_n_i = 1'b1, h_scl, h_sda;
    logic scl_i, scl_o, scl_oe_n_o, sda_i, sda_o, sda_oe_n_o, alert_o, alert_oe_n_o;
    logic adapter_path_switch_o, battery_path_switch_o, ref_5v_regulator_en_o;
    logic ref_5v_pulldown_o, charge_en_o, volt_cell4_o, volt_precharge_o, ok;
    logic [6:0]  volt_dac_o;
    logic [7:0]  current_setpoint_dac_o, input_limit_dac_o, c;
    logic [15:0] operating_mode_o, v, g;
    int          miscompares = 0, checks_done = 0, cyc = 0;
    wire  [5:0]  pins = {adapter_path_switch_o, battery_path_switch_o,
                         ref_5v_regulator_en_o, ref_5v_pulldown_o, charge_en_o, alert_oe_n_o};
    // command, data, expected {precharge, cell4, code} or dac byte
    logic [32:0] rows [7] = '{{CMD_VSET, 16'h2328, 9'h100}, {CMD_VSET, 16'h4B00, 9'h0FF},
        {CMD_VSET, 16'h4E20, 9'h0FF}, {CMD_VSET, 16'h3E80, 9'h080},
        {CMD_VSET, 16'h3083, 9'h016}, {CMD_ISET, 16'h7F80, 9'h0FF},
        {CMD_ILIM, 16'h0080, 9'h001}};
    // short delays keep the adapter sequence within a few dozen cycles
    csc_regs_top #(.ADP_DELAY_CYC(20), .REF_DELAY_CYC(10)) uut (.*);
    csc_host h (.mclk_i(mclk_i), .sda_i(sda_i), .scl_o(h_scl), .sda_o(h_sda));
    // wired-and of host and device on the open-drain lines
    assign scl_i = h_scl & (scl_oe_n_o | scl_o);
    assign sda_i = h_sda & (sda_oe_n_o | sda_o);
    always #50 mclk_i = ~mclk_i;
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] q);
        checks_done++;
        if (q !== e)
        begin
            miscompares++;
            $display("mismatch %s exp %h got %h", n, e, q);
        end
    endtask : chk
    task automatic give_verdict;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict
    // hang guard, about three and a half times the expected run
    always @(posedge mclk_i)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            miscompares++;
            give_verdict();
        end
    end
    // main sequence
    initial
    begin
        repeat (12) @(posedge mclk_i);
        rst_i <= 1'b0;
        repeat (10) @(posedge mclk_i);
        chk("pins", 16'h0015, 16'(pins));
        chk("od", 16'h0008, 16'({scl_oe_n_o, scl_o, sda_o, alert_o}));
        chk("mode", MODE_RST, operating_mode_o);
        h.rd(CMD_VSET, v, ok);
        chk("vset", SETP_RST, v);
        foreach (rows[i])
        begin
            c = rows[i][32:25];
            h.wr(SMB_ADDR, c, rows[i][24:9], ok);
            chk("ack", 16'h0001, 16'(ok));
            g = (c == CMD_VSET) ? {7'h00, volt_precharge_o, volt_cell4_o, volt_dac_o}
              : (c == CMD_ISET) ? {8'h00, current_setpoint_dac_o} : {8'h00, input_limit_dac_o};
            chk("dac", 16'(rows[i][8:0]), g);
        end
        h.rd(CMD_ISET, v, ok);
        chk("iset", 16'h7F80, v);
        chk("alert", 16'h0000, 16'(alert_oe_n_o));
        // status is read-only: the word is acked but must not land
        h.wr(SMB_ADDR, CMD_STAT, 16'h00FF, ok);
        chk("ack", 16'h0001, 16'(ok));
        h.rd(CMD_STAT, v, ok);
        chk("stat", 16'h0041, v);
        chk("alert", 16'h0001, 16'(alert_oe_n_o));
        h.wr(SMB_ADDR, CMD_VSET, 16'h3A98, ok);
        chk("alert", 16'h0000, 16'(alert_oe_n_o));
        h.rd(CMD_STAT, v, ok);
        chk("stat", 16'h0061, v);
        h.wr(SMB_ADDR, CMD_VSET, 16'h3070, ok);
        h.wr(8'h14, CMD_MODE, 16'h0000, ok);
        chk("ack", 16'h0000, 16'(ok));
        h.wr(SMB_ADDR, 8'h20, 16'h0000, ok);
        chk("ack", 16'h0000, 16'(ok));
        chk("mode", MODE_RST, operating_mode_o);
        adapter_detect_i <= 1'b1;
        gate_drive_full_i <= 1'b1;
        charge_enable_n_i <= 1'b0;
        repeat (12) @(posedge mclk_i);
        chk("paths", 16'h0001, 16'(pins[5:4]));
        repeat (40) @(posedge mclk_i);
        chk("pins", 16'h0028, 16'(pins));
        h.wr(SMB_ADDR, CMD_MODE, 16'h0000, ok);
        chk("pins", 16'h002A, 16'(pins));
        h.rd(CMD_STAT, v, ok);
        chk("stat", 16'h0080, v);
        h.wr(SMB_ADDR, CMD_ISET, 16'h0000, ok);
        chk("chg", 16'h0000, 16'(charge_en_o));
        h.wr(SMB_ADDR, CMD_MODE, 16'h0002, ok);
        chk("paths", 16'h0001, 16'(pins[5:4]));
        adapter_detect_i <= 1'b0;
        repeat (12) @(posedge mclk_i);
        chk("pins", 16'h0014, 16'(pins));
        // second reset mid-run: written setpoints must fall back to their reset values
        rst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        repeat (10) @(posedge mclk_i);
        chk("mode", MODE_RST, operating_mode_o);
        chk("ilim", 16'h0000, 16'(input_limit_dac_o));
        chk("vdac", 16'h0000, 16'(volt_dac_o));
        give_verdict();
    end
endmodule : tb_top
